// ### hw/fcl_pkg.sv
package fcl_pkg;
   localparam int ADDR_W  = 22;
   localparam int DATA_W  = 16;
   localparam int BANKS   = 4;
   localparam int SECTORS = 128;

   // command cycle addresses and data
   localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
   localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
   localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
   localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
   localparam logic [7:0]  CMD_LOCK     = 8'h60;
   localparam logic [7:0]  CMD_RESET    = 8'hF0;
   localparam logic [7:0]  CMD_ASEL     = 8'h90;
   localparam logic [7:0]  CMD_CFG      = 8'hC0;
   localparam logic [7:0]  CMD_PROG     = 8'hA0;
   localparam logic [7:0]  CMD_ERASE    = 8'h80;
   localparam logic [7:0]  CMD_SECT_ERS = 8'h30;
   localparam logic [7:0]  CMD_CHIP_ERS = 8'h10;

   // configuration, lock-select, bank and sector fields carried on address bits
   localparam int CFG_READ_MODE_BIT = 19;
   localparam int CFG_RDY_BIT       = 18;
   localparam int CFG_EDGE_BIT      = 17;
   localparam int CFG_BLEN_HI       = 16;
   localparam int CFG_BLEN_LO       = 15;
   localparam int CFG_WAIT_HI       = 14;
   localparam int CFG_WAIT_LO       = 12;
   localparam int LOCK_SEL_BIT      = 6;
   localparam int BANK_HI           = 21;
   localparam int BANK_LO           = 20;
   localparam int SECT_LO           = 15;

   // autoselect offsets and answers
   localparam logic [7:0]  ASEL_MFR     = 8'h00;
   localparam logic [7:0]  ASEL_DEVID1  = 8'h01;
   localparam logic [7:0]  ASEL_LOCK    = 8'h02;
   localparam logic [7:0]  ASEL_HSHAKE  = 8'h03;
   localparam logic [7:0]  ASEL_DEVID2  = 8'h0E;
   localparam logic [7:0]  ASEL_DEVID3  = 8'h0F;
   localparam logic [15:0] SECT_LOCKED  = 16'h0001;
   localparam logic [15:0] SECT_OPEN    = 16'h0000;
   localparam logic [15:0] HS_REDUCED   = 16'h0043;
   localparam logic [15:0] HS_STANDARD  = 16'h0042;

   // first data on edge number wait code plus this
   localparam logic [3:0] WAIT_BASE = 4'h2;

   typedef struct packed {
      logic       async_mode;
      logic       rdy_with_data;
      logic       rising_edge;
      logic [1:0] burst_len;
      logic [2:0] wait_code;
   } fcl_cfg_t;

   localparam fcl_cfg_t CFG_RESET = '{1'b1, 1'b1, 1'b1, 2'h0, 3'h5};

   typedef enum logic [2:0] {
      BM_READ = 3'b001,
      BM_LOCK = 3'b010,
      BM_ASEL = 3'b100
   } fcl_bank_mode_t;

   typedef enum logic [8:0] {
      SQ_IDLE = 9'b000000001,
      SQ_UNL1 = 9'b000000010,
      SQ_UNL2 = 9'b000000100,
      SQ_PROG = 9'b000001000,
      SQ_ERS1 = 9'b000010000,
      SQ_ERS2 = 9'b000100000,
      SQ_ERS3 = 9'b001000000,
      SQ_LCK1 = 9'b010000000,
      SQ_LCK2 = 9'b100000000
   } fcl_seq_t;
endpackage

// ### hw/fcl_cmd.sv
`timescale 1ns/100ps
module fcl_cmd
   import fcl_pkg::*;
#(
   parameter logic [15:0] MFR_CODE   = 16'h00A5, // arbitrary value
   parameter logic [15:0] DEV_WORD1  = 16'h1111, // arbitrary value
   parameter logic [15:0] DEV_WORD2  = 16'h1122, // arbitrary value
   parameter logic [15:0] DEV_WORD3  = 16'h1133, // arbitrary value
   parameter logic        REDUCED_HS = 1'b0
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_reset,
   input  wire logic                 i_we,
   input  wire logic                 i_re,
   input  wire logic [ADDR_W-1:0]    i_addr,
   input  wire logic [DATA_W-1:0]    i_wdata,
   input  wire logic                 i_wp_n,
   input  wire logic [BANKS-1:0]     i_timeout_fail_flag,
   input  wire logic [BANKS-1:0]     i_algo_done,
   input  wire logic                 i_address_valid_strobe_n,
   input  wire logic                 i_active_edge,
   output logic      [DATA_W-1:0]    o_rdata,
   output logic                      o_rvalid,
   output logic                      o_array_rd,
   output logic                      o_prog_start,
   output logic                      o_erase_start,
   output logic                      o_chip_erase,
   output logic      [1:0]           o_op_bank,
   output logic      [BANKS-1:0]     o_bank_busy,
   output logic      [BANKS-1:0]     o_bank_asel,
   output logic      [BANKS-1:0]     o_bank_lockmode,
   output fcl_cfg_t                  o_cfg,
   output logic                      o_data_valid,
   output logic                      o_ready
);

   typedef struct packed {
      fcl_cfg_t                        cfg;
      fcl_bank_mode_t [BANKS-1:0]      mode;
      logic           [BANKS-1:0]      busy;
      fcl_seq_t                        seq;
      logic           [SECTORS-1:0]    locked;
      logic           [DATA_W-1:0]     rdata;
      logic                            rvalid;
      logic                            array_rd;
      logic                            prog_start;
      logic                            erase_start;
      logic                            chip_erase;
      logic           [1:0]            op_bank;
      logic                            avd;
      logic                            run;
      logic                            single;
      logic           [3:0]            cnt;
      logic                            dv;
      logic                            rdy;
   } fcl_state_t;

   fcl_state_t s_q;
   fcl_state_t s_d;

   logic [1:0]  w_bank;
   logic [6:0]  w_sec;
   logic [7:0]  w_cmd;
   logic [7:0]  w_offs;
   logic        w_unl1;
   logic        w_unl2;
   logic        w_run_busy;
   logic [3:0]  w_first;
   logic [3:0]  w_next;
   logic        w_avd_rise;

   assign w_bank     = i_addr[BANK_HI:BANK_LO];
   assign w_sec      = i_addr[BANK_HI:SECT_LO];
   assign w_cmd      = i_wdata[7:0];
   assign w_offs     = i_addr[7:0];
   assign w_unl1     = (i_addr[11:0] == UNLOCK1_ADDR) &&
                       (w_cmd == UNLOCK1_DATA);
   assign w_unl2     = (i_addr[11:0] == UNLOCK2_ADDR) &&
                       (w_cmd == UNLOCK2_DATA);
   assign w_run_busy = s_q.busy[w_bank] && !i_algo_done[w_bank];
   assign w_first    = {1'b0, s_q.cfg.wait_code} + WAIT_BASE;
   assign w_next     = (s_q.cnt == 4'hF) ? s_q.cnt : s_q.cnt + 4'h1;
   assign w_avd_rise = !s_q.avd && i_address_valid_strobe_n;

   // write-protect overrides the lock bit of the two outermost sectors
   function automatic logic sector_locked(input logic [SECTORS-1:0] lk,
                                          input logic [6:0] sec,
                                          input logic wp_n);
      logic outer;
      outer = (sec == 7'h00) || (sec == 7'h7F);
      sector_locked = lk[sec] || (outer && !wp_n);
   endfunction

   always_comb begin
      s_d             = s_q;
      s_d.rvalid      = 1'b0;
      s_d.array_rd    = 1'b0;
      s_d.prog_start  = 1'b0;
      s_d.erase_start = 1'b0;
      s_d.chip_erase  = 1'b0;
      s_d.dv          = 1'b0;
      s_d.avd         = i_address_valid_strobe_n;
      s_d.busy        = s_q.busy & ~i_algo_done;

      if (i_we) begin
         if (w_run_busy) begin
            if (w_cmd == CMD_RESET && i_timeout_fail_flag[w_bank]) begin
               s_d.busy[w_bank] = 1'b0;
               s_d.mode[w_bank] = BM_READ;
               s_d.seq          = SQ_IDLE;
            end
         end else if (w_cmd == CMD_RESET) begin
            s_d.mode[w_bank] = BM_READ;
            s_d.seq          = SQ_IDLE;
         end else begin
            unique case (s_q.seq)
               SQ_IDLE: begin
                  if (s_q.mode[w_bank] == BM_LOCK && w_cmd == CMD_LOCK) begin
                     s_d.locked[w_sec] = !i_addr[LOCK_SEL_BIT];
                  end else if (w_unl1) begin
                     s_d.seq = SQ_UNL1;
                  end else if (w_cmd == CMD_LOCK) begin
                     s_d.seq = SQ_LCK1;
                  end
               end
               SQ_UNL1: begin
                  s_d.seq = w_unl2 ? SQ_UNL2 : SQ_IDLE;
               end
               SQ_UNL2: begin
                  s_d.seq = SQ_IDLE;
                  if (w_cmd == CMD_ASEL) begin
                     s_d.mode[w_bank] = BM_ASEL;
                  end else if (w_cmd == CMD_PROG) begin
                     s_d.seq = SQ_PROG;
                  end else if (w_cmd == CMD_ERASE) begin
                     s_d.seq = SQ_ERS1;
                  end else if (w_cmd == CMD_CFG) begin
                     s_d.cfg.async_mode    = i_addr[CFG_READ_MODE_BIT];
                     s_d.cfg.rdy_with_data = i_addr[CFG_RDY_BIT];
                     s_d.cfg.rising_edge   = i_addr[CFG_EDGE_BIT];
                     s_d.cfg.burst_len     = i_addr[CFG_BLEN_HI:CFG_BLEN_LO];
                     s_d.cfg.wait_code     = i_addr[CFG_WAIT_HI:CFG_WAIT_LO];
                  end
               end
               SQ_PROG: begin
                  s_d.seq = SQ_IDLE;
                  if (!sector_locked(s_q.locked, w_sec, i_wp_n)) begin
                     s_d.busy[w_bank] = 1'b1;
                     s_d.prog_start   = 1'b1;
                     s_d.op_bank      = w_bank;
                  end
               end
               SQ_ERS1: begin
                  s_d.seq = w_unl1 ? SQ_ERS2 : SQ_IDLE;
               end
               SQ_ERS2: begin
                  s_d.seq = w_unl2 ? SQ_ERS3 : SQ_IDLE;
               end
               SQ_ERS3: begin
                  s_d.seq = SQ_IDLE;
                  if (w_cmd == CMD_CHIP_ERS) begin
                     s_d.busy[w_bank] = 1'b1;
                     s_d.erase_start  = 1'b1;
                     s_d.chip_erase   = 1'b1;
                     s_d.op_bank      = w_bank;
                  end else if (w_cmd == CMD_SECT_ERS &&
                               !sector_locked(s_q.locked, w_sec, i_wp_n)) begin
                     s_d.busy[w_bank] = 1'b1;
                     s_d.erase_start  = 1'b1;
                     s_d.op_bank      = w_bank;
                  end
               end
               SQ_LCK1: begin
                  s_d.seq = (w_cmd == CMD_LOCK) ? SQ_LCK2 : SQ_IDLE;
               end
               SQ_LCK2: begin
                  s_d.seq = SQ_IDLE;
                  if (w_cmd == CMD_LOCK) begin
                     s_d.mode[w_bank]  = BM_LOCK;
                     s_d.locked[w_sec] = !i_addr[LOCK_SEL_BIT];
                  end
               end
            endcase
         end
      end

      if (i_re) begin
         if (s_q.mode[w_bank] == BM_ASEL) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = '0;
            unique case (w_offs)
               ASEL_MFR:    s_d.rdata = MFR_CODE;
               ASEL_DEVID1: s_d.rdata = DEV_WORD1;
               ASEL_DEVID2: s_d.rdata = DEV_WORD2;
               ASEL_DEVID3: s_d.rdata = DEV_WORD3;
               ASEL_LOCK:   s_d.rdata = sector_locked(s_q.locked, w_sec,
                                           i_wp_n) ? SECT_LOCKED : SECT_OPEN;
               ASEL_HSHAKE: s_d.rdata = REDUCED_HS ? HS_REDUCED : HS_STANDARD;
               default:     s_d.rdata = '0;
            endcase
         end else if (s_q.mode[w_bank] == BM_READ) begin
            // lock-mode bank gets no array read
            s_d.array_rd = 1'b1;
         end
      end

      // burst timing counts active edges after the strobe returns high
      if (!i_address_valid_strobe_n) begin
         s_d.run = 1'b0;
         s_d.rdy = 1'b0;
         s_d.cnt = '0;
      end else if (w_avd_rise && !s_q.cfg.async_mode) begin
         s_d.run    = 1'b1;
         s_d.cnt    = '0;
         s_d.single = (s_q.mode[w_bank] == BM_ASEL);
      end else if (s_q.run && i_active_edge) begin
         s_d.cnt = w_next;
         s_d.dv  = (w_next >= w_first);
         if (s_q.cfg.rdy_with_data || s_q.cfg.wait_code == 3'h0) begin
            s_d.rdy = (w_next >= w_first);
         end else begin
            s_d.rdy = (w_next >= w_first - 4'h1);
         end
         if (s_q.single && w_next >= w_first) begin
            s_d.run = 1'b0;
            s_d.rdy = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         s_q          <= '0;
         s_q.cfg      <= CFG_RESET;
         s_q.mode     <= '{default: BM_READ};
         s_q.seq      <= SQ_IDLE;
         s_q.locked   <= '1;
         s_q.avd      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // edge and length go to the pad and address logic
   assign o_cfg           = s_q.cfg;
   assign o_rdata         = s_q.rdata;
   assign o_rvalid        = s_q.rvalid;
   assign o_array_rd      = s_q.array_rd;
   assign o_prog_start    = s_q.prog_start;
   assign o_erase_start   = s_q.erase_start;
   assign o_chip_erase    = s_q.chip_erase;
   assign o_op_bank       = s_q.op_bank;
   assign o_bank_busy     = s_q.busy;
   assign o_data_valid    = s_q.dv;
   assign o_ready         = s_q.rdy;

   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      assign o_bank_asel[b]     = (s_q.mode[b] == BM_ASEL);
      assign o_bank_lockmode[b] = (s_q.mode[b] == BM_LOCK);
   end

   AST_CFG_CAPTURE: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_we && s_q.seq == SQ_UNL2 && w_cmd == CMD_CFG && !w_run_busy) |=>
      (o_cfg.async_mode == $past(i_addr[CFG_READ_MODE_BIT])) &&
      (o_cfg.wait_code == $past(i_addr[CFG_WAIT_HI:CFG_WAIT_LO])))
      else $error("configuration not captured from address");
   AST_CFG_DEFAULT: assert property (@(posedge i_clock) disable iff (i_reset)
      $past(i_reset) |-> (o_cfg == CFG_RESET))
      else $error("configuration not default after reset");
   AST_ALL_LOCKED: assert property (@(posedge i_clock) disable iff (i_reset)
      $past(i_reset) |-> (&s_q.locked))
      else $error("sectors not locked after reset");
   AST_LOCK_THIRD: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_we && s_q.seq == SQ_LCK2 && w_cmd == CMD_LOCK && !w_run_busy) |=>
      (s_q.locked[$past(w_sec)] == !$past(i_addr[LOCK_SEL_BIT])) &&
      o_bank_lockmode[$past(w_bank)])
      else $error("lock write did not take");
   AST_LOCK_NO_READ: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_re && o_bank_lockmode[w_bank]) |=> !o_array_rd && !o_rvalid)
      else $error("lock-mode bank served a read");
   AST_WP_OUTER: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_we && s_q.seq == SQ_PROG && !i_wp_n && w_sec == 7'h00 &&
       !w_run_busy) |=> !o_prog_start)
      else $error("protected sector programmed");
   AST_BUSY_IGNORE: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_we && w_run_busy && w_cmd == CMD_RESET &&
       !i_timeout_fail_flag[w_bank]) |=> o_bank_busy[$past(w_bank)])
      else $error("reset accepted during running algorithm");
   AST_TIMEOUT_RESET: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_we && w_run_busy && w_cmd == CMD_RESET &&
       i_timeout_fail_flag[w_bank]) |=> !o_bank_busy[$past(w_bank)])
      else $error("reset after timeout did not free bank");
   AST_ASEL_ENTRY: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_we && s_q.seq == SQ_UNL2 && w_cmd == CMD_ASEL && !w_run_busy) |=>
      o_bank_asel[$past(w_bank)])
      else $error("autoselect not entered");
   AST_HANDSHAKE: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_re && o_bank_asel[w_bank] && w_offs == ASEL_HSHAKE) |=>
      o_rvalid && (o_rdata == (REDUCED_HS ? HS_REDUCED : HS_STANDARD)))
      else $error("wrong handshaking answer");
   AST_WAIT_EDGE: assert property (@(posedge i_clock) disable iff (i_reset)
      (o_data_valid |-> (s_q.cnt >= w_first)) and
      ((s_q.cnt == w_first && $changed(s_q.cnt)) |-> o_data_valid))
      else $error("first data on wrong edge");
   AST_ASEL_SINGLE: assert property (@(posedge i_clock) disable iff (i_reset)
      (o_data_valid && s_q.single && i_address_valid_strobe_n) |=>
      !o_data_valid [*4])
      else $error("autoselect burst gave a second word");
endmodule

// ### tb/fcl_host.sv
`timescale 1ns/100ps
module fcl_host
   import fcl_pkg::*;
(
   input  wire logic              i_clock,
   output logic                   o_we,
   output logic                   o_re,
   output logic      [ADDR_W-1:0] o_addr,
   output logic      [DATA_W-1:0] o_wdata
);
   initial begin
      o_we = 1'b0;
      o_re = 1'b0;
      o_addr = '0;
      o_wdata = '0;
   end
   // released lines show the inverse, so a stale value never looks valid
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_we <= 1'b1;
      o_addr <= a;
      o_wdata <= {8'h00, d};
      @(posedge i_clock);
      o_we <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~{8'h00, d};
   endtask
   // answer is looked at just after the edge that took the read
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge i_clock);
      o_re <= 1'b1;
      o_addr <= a;
      @(posedge i_clock);
      o_re <= 1'b0;
      o_addr <= ~a;
      #1;
   endtask
   task automatic unl(input logic [1:0] b);
      wr({b, 8'h00, UNLOCK1_ADDR}, UNLOCK1_DATA);
      wr({b, 8'h00, UNLOCK2_ADDR}, UNLOCK2_DATA);
   endtask
   // only sent while no bank is busy
   task automatic asel(input logic [1:0] b);
      unl(b);
      wr({b, 8'h00, UNLOCK1_ADDR}, CMD_ASEL);
   endtask
   // bank twice, then sector with bit 6
   task automatic lock(input logic [6:0] s, input logic un);
      wr({s[6:5], 8'h00, UNLOCK1_ADDR}, CMD_LOCK);
      wr({s[6:5], 8'h00, UNLOCK1_ADDR}, CMD_LOCK);
      lock1(s, un);
   endtask
   // further sectors of the same bank
   task automatic lock1(input logic [6:0] s, input logic un);
      wr({s, 8'h00, un, 6'h00}, CMD_LOCK);
   endtask
   task automatic leave(input logic [ADDR_W-1:0] a);
      wr(a, CMD_RESET);
   endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
   import fcl_pkg::*;
   localparam logic [15:0] MFR = 16'h005A; // arbitrary value
   localparam logic [15:0] ID1 = 16'h0A01; // arbitrary value
   localparam logic [15:0] ID2 = 16'h0A02; // arbitrary value
   localparam logic [15:0] ID3 = 16'h0A03; // arbitrary value
   localparam logic [21:0] BA0 = {2'd0, 8'h00, UNLOCK1_ADDR};
   localparam logic [21:0] S5  = {7'd5, 15'h0000};
   logic              i_clock, i_reset, we, re, wp_n, avs_n, act_edge;
   logic [21:0]       addr;
   logic [15:0]       wdata, rdata;
   logic [3:0]        tfail, done, busy, asel, lockm;
   logic              rvalid, array_rd, prog_st, ers_st, dv, rdy, chip_st;
   logic [1:0]        op_bank;
   fcl_cfg_t          cfg;
   int                n_mismatch, check_count, n_prog, n_ers, n_chip;

   fcl_cmd #(.MFR_CODE(MFR), .DEV_WORD1(ID1), .DEV_WORD2(ID2),
      .DEV_WORD3(ID3), .REDUCED_HS(1'b0)) DUT (
      .i_clock(i_clock), .i_reset(i_reset), .i_we(we), .i_re(re),
      .i_addr(addr), .i_wdata(wdata), .i_wp_n(wp_n),
      .i_timeout_fail_flag(tfail), .i_algo_done(done),
      .i_address_valid_strobe_n(avs_n), .i_active_edge(act_edge),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_array_rd(array_rd),
      .o_prog_start(prog_st), .o_erase_start(ers_st),
      .o_chip_erase(chip_st),
      .o_op_bank(op_bank), .o_bank_busy(busy), .o_bank_asel(asel),
      .o_bank_lockmode(lockm), .o_cfg(cfg), .o_data_valid(dv),
      .o_ready(rdy));
   fcl_host h (.i_clock(i_clock), .o_we(we), .o_re(re), .o_addr(addr),
      .o_wdata(wdata));

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      if (prog_st === 1'b1) n_prog <= n_prog + 1;
      if (ers_st === 1'b1) n_ers <= n_ers + 1;
      if (chip_st === 1'b1) n_chip <= n_chip + 1;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic settle;
      repeat (2) @(posedge i_clock);
      #1;
   endtask
   task automatic do_reset;
      @(posedge i_clock);
      i_reset <= 1'b1;
      repeat (10) @(posedge i_clock);
      i_reset <= 1'b0;
      #1;
      chk({8'h00, cfg}, {8'h00, CFG_RESET});
      chk({busy, asel, lockm, 4'h0}, 16'h0000);
   endtask
   task automatic setcfg(input fcl_cfg_t c);
      h.unl(2'd0);
      h.wr({2'b00, c, UNLOCK1_ADDR}, CMD_CFG);
      #1;
      chk({8'h00, cfg}, {8'h00, c});
   endtask
   task automatic t_config;
      fcl_cfg_t c;
      for (int i = 0; i < 6; i++) begin
         c = fcl_cfg_t'({i[0], ~i[0], i[1], i[1:0], i[2:0]});
         setcfg(c);
      end
      do_reset();
   endtask
   // count only starts on a rising strobe in burst mode
   task automatic burst(input fcl_cfg_t c);
      int w, e;
      w = int'(c.wait_code);
      e = (!c.rdy_with_data && w != 0) ? 1 : 0;
      setcfg(c);
      @(posedge i_clock);
      avs_n <= 1'b0;
      @(posedge i_clock);
      avs_n <= 1'b1;
      for (int n = 1; n <= 8; n++) begin
         @(posedge i_clock);
         act_edge <= 1'b1;
         @(posedge i_clock);
         act_edge <= 1'b0;
         #1;
         chk(16'(dv), 16'(!c.async_mode && n >= w + 2));
         chk(16'(rdy), 16'(!c.async_mode && n >= w + 2 - e));
      end
      @(posedge i_clock);
      avs_n <= 1'b0;
      settle();
      chk(16'(rdy), 16'h0000);
   endtask
   task automatic t_asel;
      logic [15:0] exp [5];
      logic [7:0]  off [5];
      int          m;
      exp = '{MFR, ID1, ID2, ID3, HS_STANDARD};
      off = '{ASEL_MFR, ASEL_DEVID1, ASEL_DEVID2, ASEL_DEVID3, ASEL_HSHAKE};
      h.asel(2'd1);
      #1;
      chk(16'(asel), 16'h0002);
      for (int k = 0; k < 5; k++) begin
         h.rd({2'd1, 12'(k * 12'h111), off[k]});
         chk(16'(rvalid), 16'h0001);
         chk(rdata, exp[k]);
      end
      m = 0;
      @(posedge i_clock);
      avs_n <= 1'b0;
      fork
         h.rd({2'd1, 12'h000, ASEL_HSHAKE});
         begin
            @(posedge i_clock);
            avs_n <= 1'b1;
         end
      join
      chk(16'(rvalid), 16'h0001);
      chk(rdata, HS_STANDARD);
      for (int n = 1; n <= 8; n++) begin
         @(posedge i_clock);
         act_edge <= 1'b1;
         @(posedge i_clock);
         act_edge <= 1'b0;
         #1;
         if (dv === 1'b1) m++;
      end
      chk(16'(m), 16'h0001);
      h.leave({2'd1, 8'hC3, 12'hABC});
      #1;
      chk(16'(asel), 16'h0000);
      h.rd({2'd1, 20'h00010});
      chk(16'(array_rd), 16'h0001);
   endtask
   task automatic t_lock;
      h.asel(2'd0);
      h.rd({7'd5, 7'h00, ASEL_LOCK});
      chk(rdata, SECT_LOCKED);
      h.leave(BA0);
      h.lock(7'd5, 1'b1);
      #1;
      chk(16'(lockm), 16'h0001);
      h.rd(S5);
      chk(16'({rvalid, array_rd}), 16'h0000);
      h.lock1(7'd0, 1'b1);
      h.leave(BA0);
      #1;
      chk(16'(lockm), 16'h0000);
      h.asel(2'd0);
      h.rd({7'd5, 7'h00, ASEL_LOCK});
      chk(rdata, SECT_OPEN);
      @(posedge i_clock);
      wp_n <= 1'b0;
      h.rd({7'd0, 7'h00, ASEL_LOCK});
      chk(rdata, SECT_LOCKED);
      @(posedge i_clock);
      wp_n <= 1'b1;
      h.rd({7'd0, 7'h00, ASEL_LOCK});
      chk(rdata, SECT_OPEN);
      h.leave(BA0);
   endtask
   task automatic t_prog;
      int p;
      p = n_prog;
      h.unl(2'd0);
      h.wr(BA0, CMD_PROG);
      h.wr(22'h0ABCDE, CMD_RESET);
      h.wr(S5, 8'h12);
      settle();
      chk(16'(n_prog - p), 16'h0000);
      h.unl(2'd0);
      h.wr(BA0, CMD_PROG);
      h.wr(S5, 8'h12);
      settle();
      chk({12'(n_prog - p), busy}, 16'h0011);
      h.leave(BA0);
      settle();
      chk(16'(busy), 16'h0001);
      @(posedge i_clock);
      tfail <= 4'h1;
      h.leave(BA0);
      settle();
      chk(16'(busy), 16'h0000);
      tfail <= 4'h0;
   endtask
   task automatic t_erase;
      int e;
      e = n_ers;
      h.unl(2'd0);
      h.wr(BA0, CMD_ERASE);
      h.unl(2'd0);
      h.leave(BA0);
      h.wr(S5, CMD_SECT_ERS);
      settle();
      chk(16'(n_ers - e), 16'h0000);
      h.unl(2'd0);
      h.wr(BA0, CMD_ERASE);
      h.unl(2'd0);
      h.wr(S5, CMD_SECT_ERS);
      h.leave(BA0);
      settle();
      chk({12'(n_ers - e), busy}, 16'h0011);
      @(posedge i_clock);
      done <= 4'hF;
      @(posedge i_clock);
      done <= 4'h0;
      settle();
      chk(16'(busy), 16'h0000);
      h.unl(2'd2);
      h.wr({2'd2, 8'h00, UNLOCK1_ADDR}, CMD_ERASE);
      h.unl(2'd2);
      h.wr({2'd2, 8'h00, UNLOCK1_ADDR}, CMD_CHIP_ERS);
      settle();
      chk({8'(n_ers - e), 4'(n_chip), busy}, 16'h0214);
      chk(16'(op_bank), 16'h0002);
      @(posedge i_clock);
      tfail <= 4'hF;
      h.leave({2'd2, 20'h00000});
      settle();
      chk(16'(busy), 16'h0000);
      tfail <= 4'h0;
   endtask

   initial begin
      i_reset = 1'b1;
      wp_n = 1'b1;
      avs_n = 1'b1;
      act_edge = 1'b0;
      tfail = 4'h0;
      done = 4'h0;
      do_reset();
      t_config();
      burst('{1'b1, 1'b1, 1'b1, 2'h0, 3'h2});
      burst('{1'b0, 1'b0, 1'b1, 2'h1, 3'h3});
      burst('{1'b0, 1'b1, 1'b0, 2'h2, 3'h0});
      burst('{1'b0, 1'b0, 1'b1, 2'h3, 3'h5});
      t_asel();
      t_lock();
      t_prog();
      t_erase();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      n_mismatch++;
      finish_test();
   end
endmodule
